// >>> design/clock_source_select_tune.sv
// Notes on behaviour
// - divider mode drives output pin quarter clock
// - gpio divider-free mode releases output pin
// - internal div4 mode: input gpio, output quarter
// - internal gpio mode frees both pins
// - select field picks eight internal frequencies
// - reset loads select field with 4 MHz code
// - fast oscillator runs when field nonzero and used
// - slow oscillator runs when selected and used or timers need
// - timers clocked from slow oscillator always
// - trim is 5-bit signed, resets zero
// - trim slews gradually, no completion flag
// - trim never touches slow oscillator
// - switch: start, falling edge, hold low, rising
// - stable bits update when switch connects
// - postscaler-to-postscaler switch skips start-up wait
// - select bit chooses primary or internal clock
// - reset clears system clock select bit
// - automatic switches never change select bit
// - code seven fast oscillator direct, six..one postscaled, zero slow oscillator
// - status shows external clock in use
`timescale 1ns/1ps
`default_nettype none
module clock_source_select_tune
   import clock_source_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire reg_req_s bus_req,
   output logic [7:0] rdata,
   input wire config_word_s config_word,
   input wire logic ext_clock_ready,
   input wire logic osc_input_pin,
   input wire pin_drive_s gpio_in_side,
   input wire pin_drive_s gpio_out_side,
   output pin_drive_s osc_input_drive,
   output pin_drive_s osc_output_drive,
   output logic system_clock,
   output logic slow_clock_tick,
   output logic fast_osc_run,
   output logic slow_osc_run
);
   logic [2:0] internal_freq_select;
   logic system_clk_select;
   logic [TRIM_W-1:0] trim_value;
   logic signed [TRIM_W-1:0] trim_applied;
   logic fast_osc_stable;
   logic slow_osc_stable;
   logic external_clock_active;
   switch_state_e sw_state;
   logic [2:0] active_sel;
   logic [2:0] target_sel;
   logic [7:0] ps_cnt;
   logic fast_lvl, fast_rise, fast_ready;
   logic slow_lvl, slow_rise, slow_ready;
   logic [OSC_CNT_W-1:0] fast_half;
   logic cur_lvl, cur_prev, new_lvl, new_prev;
   logic cur_fall, new_rise, new_ready;
   logic int_clk;
   logic int_use;
   logic primary_internal;
   logic ext_sync1, ext_sync2;
   logic sys_prev;
   logic [1:0] quarter_cnt;
   logic quarter_clock_out;
   logic wr_ctrl, wr_trim;

   assign wr_ctrl = bus_req.wr && (bus_req.addr == OSC_CONTROL_OFFSET);
   assign wr_trim = bus_req.wr && (bus_req.addr == FREQ_TRIM_OFFSET);
   assign primary_internal = (config_word.mode == INTERNAL_OSC_DIV4_OUT_MODE)
                          || (config_word.mode == INTERNAL_OSC_GPIO_MODE);
   // internal clock is needed whenever software, two-speed start or the mode selects it
   assign int_use = system_clk_select || config_word.two_speed_enable || primary_internal;

   // control register fields
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         internal_freq_select <= FSEL_RESET;
         system_clk_select <= CLK_SELECT_RESET;
      end else if (wr_ctrl) begin
         internal_freq_select <= bus_req.wdata[FSEL_LSB +: 3];
         // only software moves the select bit; automatic switches leave it alone
         system_clk_select <= bus_req.wdata[CLK_SELECT_BIT];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         trim_value <= TRIM_RESET;
      end else if (wr_trim) begin
         trim_value <= bus_req.wdata[TRIM_W-1:0];
      end
   end

   // trim moves one step per fast period, so the frequency drifts rather than jumps
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         trim_applied <= TRIM_RESET;
      end else if (fast_rise) begin
         if (trim_applied < $signed(trim_value)) begin
            trim_applied <= trim_applied + 5'sh01;
         end else if (trim_applied > $signed(trim_value)) begin
            trim_applied <= trim_applied - 5'sh01;
         end
      end
   end

   // higher code, shorter half period; extreme codes only approximate the trim range
   assign fast_half = OSC_CNT_W'(FAST_HALF_CYC) - OSC_CNT_W'(trim_applied);

   // oscillator enables
   always_comb begin
      fast_osc_run = ((internal_freq_select != FSEL_SLOW) || (active_sel != FSEL_SLOW))
                  && int_use;
      slow_osc_run = (((internal_freq_select == FSEL_SLOW) || (active_sel == FSEL_SLOW))
                  && int_use) || config_word.power_up_timer
                  || config_word.watchdog_timer || config_word.fail_safe_monitor;
   end

   osc_model #(.WARM_CYC(FAST_WARM_CYC)) fast_osc (
      .mclk(mclk),
      .reset(reset),
      .enable(fast_osc_run),
      .half_cycles(fast_half),
      .level(fast_lvl),
      .rise(fast_rise),
      .stable(fast_ready)
   );

   // slow oscillator has a fixed period: trim has no path to it
   osc_model #(.WARM_CYC(SLOW_WARM_CYC)) slow_osc (
      .mclk(mclk),
      .reset(reset),
      .enable(slow_osc_run),
      .half_cycles(OSC_CNT_W'(SLOW_HALF_CYC)),
      .level(slow_lvl),
      .rise(slow_rise),
      .stable(slow_ready)
   );

   // timers take the slow oscillator whatever the system clock is
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         slow_clock_tick <= 1'b0;
      end else begin
         slow_clock_tick <= slow_rise;
      end
   end

   // postscaler on the fast oscillator
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ps_cnt <= '0;
      end else if (fast_rise) begin
         ps_cnt <= ps_cnt + 1'b1;
      end
   end

   function automatic logic pick(input logic [2:0] s, input logic [7:0] ps,
                                 input logic fast, input logic slow);
      if (s == FSEL_SLOW) begin
         pick = slow;
      end else if (s == FSEL_FAST_MAX) begin
         pick = fast;
      end else begin
         pick = ps[3'(PS_TOP - s)];
      end
   endfunction

   assign cur_lvl = pick(active_sel, ps_cnt, fast_lvl, slow_lvl);
   assign new_lvl = pick(target_sel, ps_cnt, fast_lvl, slow_lvl);
   assign cur_fall = cur_prev && !cur_lvl;
   assign new_rise = !new_prev && new_lvl;
   assign new_ready = (target_sel == FSEL_SLOW) ? slow_ready : fast_ready;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cur_prev <= 1'b0;
         new_prev <= 1'b0;
      end else begin
         cur_prev <= cur_lvl;
         new_prev <= new_lvl;
      end
   end

   // glitch-free frequency switch
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sw_state <= SW_IDLE;
         active_sel <= FSEL_RESET;
         target_sel <= FSEL_RESET;
      end else begin
         case (sw_state)
            SW_IDLE: begin
               if (internal_freq_select != active_sel) begin
                  target_sel <= internal_freq_select;
                  if (!int_use) begin
                     // nothing runs on the internal clock, so no edge to protect
                     active_sel <= internal_freq_select;
                  end else if ((internal_freq_select != FSEL_SLOW)
                               && (active_sel != FSEL_SLOW)) begin
                     sw_state <= SW_FALL;
                  end else begin
                     sw_state <= SW_START;
                  end
               end
            end
            SW_START: begin
               if (new_ready) begin
                  sw_state <= SW_FALL;
               end
            end
            SW_FALL: begin
               if (cur_fall) begin
                  sw_state <= SW_RISE;
               end
            end
            SW_RISE: begin
               if (new_rise) begin
                  active_sel <= target_sel;
                  sw_state <= SW_IDLE;
               end
            end
            default: begin
               sw_state <= SW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         int_clk <= 1'b0;
      end else if (sw_state == SW_RISE) begin
         int_clk <= 1'b0;
      end else begin
         int_clk <= cur_lvl;
      end
   end

   // stable bits: cleared at once when an oscillator stops, set only when idle or as a switch connects
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fast_osc_stable <= 1'b0;
         slow_osc_stable <= 1'b0;
      end else begin
         if (!fast_ready) begin
            fast_osc_stable <= 1'b0;
         end else if (sw_state == SW_IDLE || (sw_state == SW_RISE && new_rise)) begin
            fast_osc_stable <= 1'b1;
         end
         if (!slow_ready) begin
            slow_osc_stable <= 1'b0;
         end else if (sw_state == SW_IDLE || (sw_state == SW_RISE && new_rise)) begin
            slow_osc_stable <= 1'b1;
         end
      end
   end

   // external clock pin is asynchronous
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
      end else begin
         ext_sync1 <= osc_input_pin;
         ext_sync2 <= ext_sync1;
      end
   end

   // system clock source
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         system_clock <= 1'b0;
         external_clock_active <= 1'b0;
      end else if (system_clk_select || primary_internal) begin
         system_clock <= int_clk;
         external_clock_active <= 1'b0;
      end else if (config_word.two_speed_enable && !ext_clock_ready) begin
         system_clock <= int_clk;
         external_clock_active <= 1'b0;
      end else begin
         system_clock <= ext_sync2;
         external_clock_active <= 1'b1;
      end
   end

   // quarter-rate clock from rising edges of the system clock
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sys_prev <= 1'b0;
         quarter_cnt <= '0;
      end else begin
         sys_prev <= system_clock;
         if (system_clock && !sys_prev) begin
            quarter_cnt <= quarter_cnt + 1'b1;
         end
      end
   end

   assign quarter_clock_out = quarter_cnt[1];

   // pin ownership per clock mode
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         osc_input_drive <= '0;
         osc_output_drive <= '0;
      end else begin
         case (config_word.mode)
            EXT_RESISTOR_CAP_DIV4_OUT_MODE: begin
               osc_input_drive <= '0;
               osc_output_drive <= '{out: quarter_clock_out, oe: 1'b1};
            end
            EXT_RESISTOR_CAP_GPIO_MODE: begin
               osc_input_drive <= '0;
               osc_output_drive <= gpio_out_side;
            end
            INTERNAL_OSC_DIV4_OUT_MODE: begin
               osc_input_drive <= gpio_in_side;
               osc_output_drive <= '{out: quarter_clock_out, oe: 1'b1};
            end
            INTERNAL_OSC_GPIO_MODE: begin
               osc_input_drive <= gpio_in_side;
               osc_output_drive <= gpio_out_side;
            end
            default: begin
               osc_input_drive <= '0;
               osc_output_drive <= '0;
            end
         endcase
      end
   end

   // register read, data in the following cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata <= '0;
      end else if (bus_req.rd) begin
         if (bus_req.addr == OSC_CONTROL_OFFSET) begin
            rdata <= {1'b0, internal_freq_select, external_clock_active,
                      fast_osc_stable, slow_osc_stable, system_clk_select};
         end else if (bus_req.addr == FREQ_TRIM_OFFSET) begin
            rdata <= {3'h0, trim_value};
         end else begin
            rdata <= '0;
         end
      end else begin
         rdata <= '0;
      end
   end

   fsel_reset_a: assert property (@(posedge mclk) disable iff (reset)
      $fell(reset) |-> internal_freq_select == FSEL_RESET && !system_clk_select)
      else $error("reset values of select fields wrong");

   select_sw_only_a: assert property (@(posedge mclk) disable iff (reset)
      !$stable(system_clk_select) |-> $past(wr_ctrl))
      else $error("select bit moved without a write");

   hold_low_a: assert property (@(posedge mclk) disable iff (reset)
      sw_state == SW_RISE ##1 sw_state == SW_RISE |-> !int_clk)
      else $error("internal clock not held low during switch");

   fast_skip_a: assert property (@(posedge mclk) disable iff (reset)
      sw_state == SW_IDLE && int_use && internal_freq_select != active_sel
      && internal_freq_select != FSEL_SLOW && active_sel != FSEL_SLOW
      |=> sw_state == SW_FALL) else $error("start-up wait on postscaler switch");

   fast_gate_a: assert property (@(posedge mclk) disable iff (reset)
      fast_osc_run |-> int_use && (internal_freq_select != FSEL_SLOW
      || active_sel != FSEL_SLOW)) else $error("fast oscillator on without cause");

   quarter_pin_a: assert property (@(posedge mclk) disable iff (reset)
      config_word.mode == EXT_RESISTOR_CAP_DIV4_OUT_MODE
      |=> osc_output_drive.oe && osc_output_drive.out == $past(quarter_cnt[1]))
      else $error("output pin not carrying quarter clock");

   gpio_release_a: assert property (@(posedge mclk) disable iff (reset)
      config_word.mode == INTERNAL_OSC_GPIO_MODE
      |=> osc_input_drive == $past(gpio_in_side)
      && osc_output_drive == $past(gpio_out_side))
      else $error("pins not released to gpio");

   trim_step_a: assert property (@(posedge mclk) disable iff (reset)
      !$stable(trim_applied) |-> $past(fast_rise)
      && (5'(trim_applied - $past(trim_applied)) inside {5'h01, 5'h1F}))
      else $error("trim jumped more than one step");

   trim_read_a: assert property (@(posedge mclk) disable iff (reset)
      bus_req.rd && bus_req.addr == FREQ_TRIM_OFFSET && !wr_trim
      |=> rdata == {3'h0, $past(trim_value)}) else $error("trim read wrong");

   fast_stable_clear_a: assert property (@(posedge mclk) disable iff (reset)
      !fast_ready |=> !fast_osc_stable) else $error("fast stable held while down");

   ext_status_a: assert property (@(posedge mclk) disable iff (reset)
      system_clk_select |=> !external_clock_active)
      else $error("external status set on internal clock");
endmodule
`default_nettype wire

// >>> design/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module osc_model
   import clock_source_pkg::*;
#(
   parameter int WARM_CYC = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic enable,
   input wire logic [OSC_CNT_W-1:0] half_cycles,
   output logic level,
   output logic rise,
   output logic stable
);
   logic [OSC_CNT_W-1:0] phase;
   logic [WARM_CNT_W-1:0] warm;
   logic half_done;

   assign half_done = (phase + 1'b1) >= half_cycles;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phase <= '0;
         level <= 1'b0;
         rise <= 1'b0;
      end else if (!enable) begin
         phase <= '0;
         level <= 1'b0;
         rise <= 1'b0;
      end else if (half_done) begin
         phase <= '0;
         level <= ~level;
         rise <= ~level;
      end else begin
         phase <= phase + 1'b1;
         rise <= 1'b0;
      end
   end

   // warm-up count restarts on every enable, so stable never outlives the oscillator
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         warm <= '0;
         stable <= 1'b0;
      end else if (!enable) begin
         warm <= '0;
         stable <= 1'b0;
      end else if (warm == WARM_CNT_W'(WARM_CYC - 1)) begin
         stable <= 1'b1;
      end else begin
         warm <= warm + 1'b1;
      end
   end

   stable_drop_a: assert property (@(posedge mclk) disable iff (reset)
      !enable |=> !stable) else $error("stable held with oscillator off");
endmodule
`default_nettype wire

// >>> inc/clock_source_pkg.sv
`default_nettype none
package clock_source_pkg;
   // timing
   localparam int MCLK_KHZ = 250000;
   localparam int MCLK_NS = 4;
   localparam int FAST_OSC_KHZ = 8000;
   localparam int SLOW_OSC_KHZ = 31;
   localparam int FAST_HALF_CYC = MCLK_KHZ / (2 * FAST_OSC_KHZ);
   localparam int SLOW_HALF_CYC = MCLK_KHZ / (2 * SLOW_OSC_KHZ);
   localparam int FAST_WARM_NS = 1000;
   localparam int SLOW_WARM_NS = 2000;
   localparam int FAST_WARM_CYC = (FAST_WARM_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int SLOW_WARM_CYC = (SLOW_WARM_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int OSC_CNT_W = 12;
   localparam int WARM_CNT_W = 10;
   // register map
   localparam logic [3:0] OSC_CONTROL_OFFSET = 4'h0;
   localparam logic [3:0] FREQ_TRIM_OFFSET = 4'h1;
   localparam int FSEL_LSB = 4;
   localparam int EXT_ACTIVE_BIT = 3;
   localparam int FAST_STABLE_BIT = 2;
   localparam int SLOW_STABLE_BIT = 1;
   localparam int CLK_SELECT_BIT = 0;
   localparam int TRIM_W = 5;
   // reset values and codes
   localparam logic [2:0] FSEL_RESET = 3'h6;
   localparam logic [2:0] FSEL_SLOW = 3'h0;
   localparam logic [2:0] FSEL_FAST_MAX = 3'h7;
   localparam logic [2:0] PS_TOP = 3'h6;
   localparam logic CLK_SELECT_RESET = 1'b0;
   localparam logic [4:0] TRIM_RESET = 5'h00;

   typedef enum logic [2:0] {
      EXT_RESISTOR_CAP_DIV4_OUT_MODE = 3'b111,
      EXT_RESISTOR_CAP_GPIO_MODE = 3'b110,
      INTERNAL_OSC_DIV4_OUT_MODE = 3'b101,
      INTERNAL_OSC_GPIO_MODE = 3'b100,
      OTHER_EXT_MODE = 3'b000
   } clock_mode_e;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_START = 2'b01,
      SW_FALL = 2'b10,
      SW_RISE = 2'b11
   } switch_state_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_s;

   typedef struct packed {
      logic [2:0] mode;
      logic two_speed_enable;
      logic power_up_timer;
      logic watchdog_timer;
      logic fail_safe_monitor;
   } config_word_s;
endpackage
`default_nettype wire

// >>> verif/tb_clock_source_select_tune.sv
`timescale 1ns/1ps
`default_nettype none
module tb_clock_source_select_tune import clock_source_pkg::*;;
   logic mclk, reset, ext_clock_ready, osc_input_pin;
   reg_req_s bus_req;
   config_word_s config_word;
   pin_drive_s gpio_in_side, gpio_out_side, osc_input_drive, osc_output_drive;
   logic [7:0] rdata, d;
   logic system_clock, slow_clock_tick, fast_osc_run, slow_osc_run, sys_q, out_q;
   logic [3:0] pin_div = 4'h0;
   clock_mode_e modes [4] = '{EXT_RESISTOR_CAP_DIV4_OUT_MODE, EXT_RESISTOR_CAP_GPIO_MODE,
      INTERNAL_OSC_DIV4_OUT_MODE, INTERNAL_OSC_GPIO_MODE};
   logic [7:0] trims [2] = '{8'h10, 8'h07};
   int fail_count = 0, checks_done = 0, sys_n = 0, out_n = 0, cyc = 0;
   int last_tick = 0, tick_gap = 0, ms, mo, h;

   clock_source_select_tune i_clock_source_select_tune (
      .mclk(mclk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
      .config_word(config_word), .ext_clock_ready(ext_clock_ready),
      .osc_input_pin(osc_input_pin), .gpio_in_side(gpio_in_side),
      .gpio_out_side(gpio_out_side), .osc_input_drive(osc_input_drive),
      .osc_output_drive(osc_output_drive), .system_clock(system_clock),
      .slow_clock_tick(slow_clock_tick), .fast_osc_run(fast_osc_run),
      .slow_osc_run(slow_osc_run)
   );

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // external clock on the input pin: one period every 16 mclk cycles
   always @(posedge mclk) begin
      pin_div <= pin_div + 4'h1;
      osc_input_pin <= pin_div[3];
   end

   // free-running edge counters; measurements take differences so no reset is needed
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      sys_q <= system_clock;
      out_q <= osc_output_drive.out;
      if (system_clock && !sys_q) sys_n <= sys_n + 1;
      if (osc_output_drive.out && !out_q) out_n <= out_n + 1;
      if (slow_clock_tick) begin
         tick_gap <= cyc - last_tick;
         last_tick <= cyc;
      end
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // edge counts over a window may be off by one from where the window falls
   task automatic near(input int seen, input int exp);
      check(seen, (seen >= exp - 1 && seen <= exp + 1) ? seen : exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic measure(input int n);
      int s0, o0;
      s0 = sys_n;
      o0 = out_n;
      settle(n);
      ms = sys_n - s0;
      mo = out_n - o0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus_req <= '{a, v, 1'b1, 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask

   initial begin
      settle(99000);
      fail_count++;
      end_of_test;
   end

   initial begin
      reset = 1'b1;
      bus_req = '0;
      config_word = {INTERNAL_OSC_DIV4_OUT_MODE, 4'b0000};
      ext_clock_ready = 1'b0;
      gpio_in_side = 2'b01;
      gpio_out_side = 2'b10;
      settle(4);
      reset <= 1'b0;
      rd(4'h0);
      check(d, 8'h60);
      rd(4'h1);
      check(d, 8'h00);
      rd(4'hF);
      check(d, 8'h00);
      wr(4'h1, 8'hFF);
      rd(4'h1);
      check(d, 8'h1F);
      wr(4'h1, 8'h00);
      $display("test registers done");

      foreach (modes[i]) begin
         @(posedge mclk);
         config_word <= {modes[i], 4'b0000};
         settle(300);
         measure(2000);
         if (modes[i][1] == 1'b0) begin
            check(osc_input_drive, gpio_in_side);
         end else begin
            check(osc_input_drive.oe, 1'b0);
         end
         if (modes[i][0]) begin
            check(osc_output_drive.oe, 1'b1);
            near(mo, ms / 4);
            near(ms, modes[i][1] ? 125 : 33);
         end else begin
            check(osc_output_drive, gpio_out_side);
         end
      end
      $display("test pin modes done");

      // walk down codes seven to one; no warm-up between them
      for (int c = 7; c >= 1; c--) begin
         wr(4'h0, {1'b0, c[2:0], 4'b0001});
         settle(2 * (30 << (7 - c)) + 300);
         measure(3840);
         near(ms, 128 >> (7 - c));
         rd(4'h0);
         check(d, {1'b0, c[2:0], 4'b0101});
      end
      $display("test frequency codes done");

      wr(4'h0, 8'h71);
      // leaving code one may wait a whole divide-by-64 period for its falling edge
      settle(600);
      foreach (trims[i]) begin
         wr(4'h1, trims[i]);
         rd(4'h1);
         check(d, trims[i]);
         h = 15 - int'($signed(trims[i][4:0]));
         settle(1500);
         measure(3840);
         near(ms, 1920 / h);
      end
      wr(4'h1, 8'h00);
      $display("test trim done");

      wr(4'h0, 8'h01);
      settle(2);
      check(slow_osc_run, 1'b1);
      settle(9000);
      rd(4'h0);
      check(d, 8'h03);
      check(fast_osc_run, 1'b0);
      wr(4'h0, 8'h71);
      settle(2);
      check(fast_osc_run, 1'b1);
      settle(9000);
      rd(4'h0);
      check(d, 8'h75);
      $display("test slow switch done");

      @(posedge mclk);
      config_word <= {OTHER_EXT_MODE, 4'b0010};
      wr(4'h0, 8'h60);
      wr(4'h1, 8'h10);
      settle(13000);
      check(slow_osc_run, 1'b1);
      check(fast_osc_run, 1'b0);
      check(tick_gap, 2 * SLOW_HALF_CYC);
      measure(1600);
      near(ms, 100);
      rd(4'h0);
      check(d, 8'h6A);
      $display("test timers done");

      @(posedge mclk);
      config_word <= {OTHER_EXT_MODE, 4'b1000};
      settle(3);
      check(fast_osc_run, 1'b1);
      rd(4'h0);
      check({d[3], d[0]}, 2'b00);
      @(posedge mclk);
      ext_clock_ready <= 1'b1;
      settle(20);
      rd(4'h0);
      check({d[3], d[0]}, 2'b10);
      $display("test two speed done");

      wr(4'h0, 8'h31);
      @(posedge mclk);
      reset <= 1'b1;
      settle(4);
      reset <= 1'b0;
      rd(4'h0);
      check(d & 8'h71, 8'h60);
      $display("test second reset done");
      end_of_test;
   end
endmodule
`default_nettype wire
